/* dv/ffpp_flash_model.sv */
// flash array stand-in: read data pattern and busy timing
`timescale 1ns/1ps
`default_nettype none
module ffpp_flash_model (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_addr,
    input  wire logic        i_start,
    output logic      [15:0] o_rdata,
    output logic             o_busy
);
    int unsigned left = 0;
    logic        prev = 1'b0;
    // read word is a fixed function of the address
    assign o_rdata = i_addr[15:0] ^ 16'hA5C3;
    // busy raised on the start edge, held a random few cycles
    assign o_busy = (i_start & ~prev) | (left != 0);
    always @(posedge i_clk) begin
        prev <= i_start;
        if (i_start & ~prev) begin
            left <= $urandom_range(5, 1);
        end else if (left != 0) begin
            left <= left - 1;
        end
    end
endmodule : ffpp_flash_model
`default_nettype wire

/* dv/tb_ffpp_port.sv */
// self-checking bench for the parallel flash programming port
`timescale 1ns/1ps
`default_nettype none
module tb_ffpp_port;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        stb_n = 1'b1;
    logic        oe_n = 1'b1;
    logic [3:0]  mode = 4'h0;
    logic [15:0] din = 16'h0000;
    logic [15:0] dout, cmd, lock_b, gp_b, wdata, rdata, got, m, c, d;
    logic [31:0] faddr, base;
    logic        doe, rdy, vld_n, fwr, frd, perase, pprog, ferase, rlock, fbusy, sec;
    int          fails = 0;
    int          check_count = 0;
    int          n_lock, n_erase;
    logic [47:0] seen_q[$];
    logic [47:0] exp_q[$];
    logic [15:0] codes[16] = '{16'h0011, 16'h0012, 16'h0022, 16'h0032, 16'h0042, 16'h0013,
        16'h0014, 16'h0024, 16'h0015, 16'h0034, 16'h0044, 16'h0025, 16'h0035, 16'h001F,
        16'h001E, 16'h0054};
    logic [15:0] wcodes[4] = '{16'h0012, 16'h0022, 16'h0032, 16'h0042};
    always #12.5 i_clk = ~i_clk;
    ffpp_port #(.PAGE_WORDS(8), .VERSION(16'h5A3C)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_cmd_strobe_n(stb_n), .i_output_enable_n(oe_n), .i_mode(mode), .i_data(din),
        .o_data(dout), .o_data_oe(doe), .o_ready(rdy), .o_data_valid_n(vld_n),
        .o_flash_addr(faddr), .o_flash_wdata(wdata), .o_flash_write(fwr),
        .o_flash_read(frd), .i_flash_rdata(rdata), .o_page_erase(perase),
        .o_page_program(pprog), .o_full_erase(ferase), .o_region_lock(rlock),
        .i_flash_busy(fbusy), .o_lock_bits(lock_b), .o_gp_bits(gp_b),
        .o_security(sec), .o_command(cmd));
    ffpp_flash_model u_flash (.i_clk(i_clk), .i_addr(faddr),
        .i_start(perase | pprog | ferase), .o_rdata(rdata), .o_busy(fbusy));
    always @(posedge i_clk) begin
        if (fwr) seen_q.push_back({faddr, wdata});
        if (rlock) n_lock++;
        if (perase) n_erase++;
    end
    // ----------------------------------------
    // handshake and check tasks
    // ----------------------------------------
    task automatic give_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [47:0] e, input logic [47:0] s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic wt(input bit sel, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (((sel ? vld_n : rdy) !== v) && n < 3000);
        if (n >= 3000) begin
            chk("handshake wait", 48'h1, 48'h0);
            give_verdict();
        end
    endtask : wt
    task automatic wr(input logic [3:0] md, input logic [15:0] dt);
        @(posedge i_clk);
        mode <= md;
        din <= dt;
        stb_n <= 1'b0;
        wt(0, 1'b0);
        @(posedge i_clk);
        din <= ~dt;
        stb_n <= 1'b1;
        wt(0, 1'b1);
    endtask : wr
    task automatic rd(output logic [15:0] q);
        @(posedge i_clk);
        mode <= 4'h5;
        stb_n <= 1'b0;
        wt(0, 1'b0);
        @(posedge i_clk);
        oe_n <= 1'b0;
        wt(1, 1'b0);
        q = dout;
        chk("data_oe", 48'h1, {47'h0, doe});
        @(posedge i_clk);
        oe_n <= 1'b1;
        wt(1, 1'b1);
        @(posedge i_clk);
        stb_n <= 1'b1;
        wt(0, 1'b1);
    endtask : rd
    initial begin
        void'($urandom(32'hdd605f74));
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        chk("reset", {29'h0, 3'b110, 16'h0}, {29'h0, rdy, vld_n, doe, cmd});
        for (int k = 0; k < 2; k++) begin
            m = 16'($urandom());
            c = 16'($urandom());
            wr(4'h0, k ? 16'h0034 : 16'h0014);
            wr(4'h5, m);
            wr(4'h0, k ? 16'h0044 : 16'h0024);
            wr(4'h5, c);
            chk("bits", {32'h0, m & ~c}, {32'h0, k ? gp_b : lock_b});
            wr(4'h0, k ? 16'h0025 : 16'h0015);
            rd(got);
            chk("bits read", {32'h0, m & ~c}, {32'h0, got});
            wr(4'h0, k ? 16'h0044 : 16'h0024);
            wr(4'h5, 16'hFFFF);
        end
        foreach (wcodes[j]) begin
            n_lock = 0;
            n_erase = 0;
            base = 32'($urandom_range(200, 0));
            wr(4'h0, wcodes[j]);
            wr(4'h1, base[15:0]);
            wr(4'h2, base[31:16]);
            for (int i = 0; i < 10 + j * 4; i++) begin
                d = 16'($urandom());
                wr(4'h5, d);
                exp_q.push_back({base + 32'(i), d});
            end
            wr(4'h0, 16'h0011);
            chk("write count", 48'(exp_q.size()), 48'(seen_q.size()));
            while (exp_q.size() > 0 && seen_q.size() > 0) begin
                chk("flash write", exp_q.pop_front(), seen_q.pop_front());
            end
            exp_q.delete();
            seen_q.delete();
            chk("lock", {47'h0, j[0]}, {47'h0, n_lock != 0});
            chk("erase", {47'h0, j > 1}, {47'h0, n_erase != 0});
        end
        for (int b = 0; b < 2; b++) begin
            base = 32'($urandom());
            wr(4'h1, base[15:0]);
            wr(4'h2, base[31:16]);
            for (int i = 0; i < 3; i++) begin
                rd(got);
                m = 16'(base + 32'(i)) ^ 16'hA5C3;
                chk("flash read", {32'h0, m}, {32'h0, got});
            end
        end
        wr(4'h3, 16'h0099);
        chk("ignored mode", {32'h0, 16'h0011}, {32'h0, cmd});
        foreach (codes[i]) begin
            wr(4'h0, codes[i]);
            chk("command", {32'h0, codes[i]}, {32'h0, cmd});
        end
        wr(4'h5, 16'h0000);
        chk("security pin", 48'h1, {47'h0, sec});
        wr(4'h0, 16'h0035);
        rd(got);
        chk("security read", 48'h1, {32'h0, got});
        wr(4'h0, 16'h001E);
        rd(got);
        chk("version", 48'h5A3C, {32'h0, got});
        give_verdict();
    end
endmodule : tb_ffpp_port
`default_nettype wire

/* rtl/ffpp_defines.svh */
// constants for the parallel flash programming port
`ifndef FFPP_DEFINES_SVH
`define FFPP_DEFINES_SVH
`define MODE_CMD        4'h0
`define MODE_ADDR_LO    4'h1
`define MODE_ADDR_HI    4'h2
`define MODE_DATA       4'h5
`define CMD_READ        16'h0011
`define CMD_PAGE_WR       16'h0012
`define CMD_PAGE_WR_LOCK  16'h0022
`define CMD_ERASE_WR      16'h0032
`define CMD_ERASE_WR_LOCK 16'h0042
`define CMD_ERASE_ALL     16'h0013
`define CMD_LOCK_SET      16'h0014
`define CMD_LOCK_CLR      16'h0024
`define CMD_LOCK_GET      16'h0015
`define CMD_GP_SET        16'h0034
`define CMD_GP_CLR        16'h0044
`define CMD_GP_GET        16'h0025
`define CMD_SEC_SET       16'h0054
`define CMD_SEC_GET       16'h0035
`define CMD_MEM_WR        16'h001F
`define CMD_VER_GET       16'h001E
`define CMD_NONE        16'h0000
`define ZERO16          16'h0000
`endif

/* rtl/ffpp_fifo.sv */
// synchronous fifo in the write data path
`timescale 1ns/1ps
`default_nettype none
module ffpp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;
    assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty       = (wr_ptr == rd_ptr);
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge i_clk) begin
        if (i_in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
        end else if (i_in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_ptr <= '0;
        end else if (i_out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
    chk_fifo_no_overflow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        full |-> !(wr_ptr != $past(wr_ptr) && $past(full)))
        else $error("fifo written while full");
endmodule : ffpp_fifo
`default_nettype wire

/* rtl/ffpp_pkg.sv */
// types for the parallel flash programming port
package ffpp_pkg;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_EXEC   = 4'b0001,
        ST_WAIT_OE = 4'b0010,
        ST_DRIVE  = 4'b0011,
        ST_WAIT_STB = 4'b0100,
        ST_FLUSH  = 4'b0101,
        ST_ERASE  = 4'b0110,
        ST_PROG   = 4'b0111,
        ST_LOCK   = 4'b1000
    } state_t;
    typedef enum logic [1:0] {
        FL_NONE = 2'b00,
        FL_CMD  = 2'b01,
        FL_PAGE = 2'b10
    } flush_reason_t;
endpackage : ffpp_pkg

/* rtl/ffpp_port.sv */
// parallel flash programming port: handshake, command decode, page buffer
//
// Overview of operation
// [RULE1] mode 0001 loads address low, 0010 address high, 0101 data; others nothing
// [RULE2] mode 0000 stores the data word as the new command
// [RULE3] decode 0x0011 read, 0x0012 page write, 0x0022 page write and lock
// [RULE4] decode 0x0032 erase-write, 0x0042 erase-write-lock, 0x0013 erase all
// [RULE5] decode 0x0014 set lock, 0x0024 clear lock, 0x0015 read lock bits
// [RULE6] decode 0x0034 set and 0x0044 clear general-purpose bits
// [RULE7] decode 0x0025 read gp bits, 0x001F memory write, 0x001E version
// [RULE8] decode 0x0054 set security, 0x0035 read security bit
// [RULE9] programmer waits 20 ms after clock before first handshake
// [RULE10] handshake starts on strobe low while ready; ends strobe high and ready
// [RULE11] write: latch on strobe low, drop ready, execute, raise ready after strobe high
// [RULE12] programmer holds mode and data until ready falls
// [RULE13] read: programmer tristates, lowers output enable, samples on data-valid low
// [RULE14] read: drive word and lower data-valid on oe low; release on oe high
// [RULE15] a new command first completes the previous one, flushing the buffer
// [RULE16] read sequence: command, address low, address high, reads with increment
// [RULE17] write sequence: command, address halves, data writes with increment
// [RULE18] load buffer of one page is programmed on page change or new command; code also programs when a data write finds the FIFO_DEPTH-entry fifo full
// [RULE19] write-and-lock sets region lock after programming
// [RULE20] erase-write erases the page before programming
// [RULE21] erase-write-lock erases, programs, then locks
// [RULE22] programmer uses lock variant only on a region's last page
// [RULE23] ready low while busy, high when a command can be taken
// [RULE24] data-valid high while bus is input, low while device drives
// [RULE25] strobe and output enable pass two flip-flops before use
// [RULE26] address is high half over low half, plus one per data handshake
`timescale 1ns/1ps
`default_nettype none
`include "ffpp_defines.svh"
module ffpp_port #(
    parameter int PAGE_WORDS = 128,
    parameter int FIFO_DEPTH = 16,
    parameter logic [15:0] VERSION = 16'h0001  // arbitrary value
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_cmd_strobe_n,
    input  wire logic        i_output_enable_n,
    input  wire logic [3:0]  i_mode,
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data,
    output logic             o_data_oe,
    output logic             o_ready,
    output logic             o_data_valid_n,
    output logic      [31:0] o_flash_addr,
    output logic      [15:0] o_flash_wdata,
    output logic             o_flash_write,
    output logic             o_flash_read,
    input  wire logic [15:0] i_flash_rdata,
    output logic             o_page_erase,
    output logic             o_page_program,
    output logic             o_full_erase,
    output logic             o_region_lock,
    input  wire logic        i_flash_busy,
    output logic      [15:0] o_lock_bits,
    output logic      [15:0] o_gp_bits,
    output logic             o_security,
    output logic      [15:0] o_command
);
    localparam int PW = $clog2(PAGE_WORDS);
    if (PAGE_WORDS < 2 || (1 << PW) != PAGE_WORDS) begin : g_bad_page
        $error("page size must be a power of two");
    end

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [1:0] stb_sync;
    logic [1:0] oe_sync;
    logic       stb_n;
    logic       oe_n;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            stb_sync <= 2'h3;
            oe_sync  <= 2'h3;
        end else begin
            stb_sync <= {stb_sync[0], i_cmd_strobe_n};  // RULE25
            oe_sync  <= {oe_sync[0], i_output_enable_n};  // RULE25
        end
    end
    assign stb_n = stb_sync[1];
    assign oe_n  = oe_sync[1];

    // ----------------------------------------
    // command helpers
    // ----------------------------------------
    function automatic logic is_write_cmd(input logic [15:0] c);
        return c == `CMD_PAGE_WR || c == `CMD_PAGE_WR_LOCK  // RULE3
            || c == `CMD_ERASE_WR || c == `CMD_ERASE_WR_LOCK;  // RULE4
    endfunction : is_write_cmd
    function automatic logic is_read_cmd(input logic [15:0] c);
        return c == `CMD_READ || c == `CMD_LOCK_GET || c == `CMD_GP_GET  // RULE5 RULE7
            || c == `CMD_SEC_GET || c == `CMD_VER_GET;  // RULE8
    endfunction : is_read_cmd

    // ----------------------------------------
    // state and registers
    // ----------------------------------------
    ffpp_pkg::state_t       state;
    logic [15:0]            command;
    logic [15:0]            addr_lo;
    logic [15:0]            addr_hi;
    logic [15:0]            lat_data;
    logic [3:0]             lat_mode;
    logic [31:0]            page_base;
    logic                   buf_dirty;
    logic [15:0]            pend_cmd;
    logic [15:0]            flush_cmd;
    logic [15:0]            lock_bits;
    logic [15:0]            gp_bits;
    logic                   security;
    logic [31:0]            addr;
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    logic [31:0]            fifo_out_addr;
    logic [15:0]            fifo_out_word;
    logic                   fifo_push;
    logic                   fifo_pop;

    assign addr = {addr_hi, addr_lo};  // RULE26

    ffpp_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (fifo_push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   ({addr, lat_data}),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  ({fifo_out_addr, fifo_out_word})
    );
    // load buffer drains into the flash page during the program phase
    assign fifo_pop = (state == ffpp_pkg::ST_PROG) && !i_flash_busy;

    // ----------------------------------------
    // handshake state machine
    // ----------------------------------------
    logic page_change;
    assign page_change = buf_dirty && (addr[31:PW] != page_base[31:PW]);
    assign fifo_push = (state == ffpp_pkg::ST_EXEC) && lat_mode == `MODE_DATA
                       && is_write_cmd(command) && !page_change && fifo_in_ready;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ffpp_pkg::ST_IDLE;
        end else begin
            unique case (state)
                ffpp_pkg::ST_IDLE: begin
                    if (!stb_n) state <= ffpp_pkg::ST_EXEC;  // RULE10 RULE11
                end
                ffpp_pkg::ST_EXEC: begin
                    if (lat_mode == `MODE_CMD && buf_dirty) begin
                        state <= ffpp_pkg::ST_FLUSH;  // RULE15 RULE18
                    end else if (lat_mode == `MODE_DATA && is_write_cmd(command)
                                 && (page_change || !fifo_in_ready)) begin
                        state <= ffpp_pkg::ST_FLUSH;  // RULE18
                    end else if (lat_mode == `MODE_DATA && is_read_cmd(command)) begin
                        state <= ffpp_pkg::ST_WAIT_OE;
                    end else begin
                        state <= ffpp_pkg::ST_WAIT_STB;
                    end
                end
                ffpp_pkg::ST_WAIT_OE: begin
                    if (!oe_n) state <= ffpp_pkg::ST_DRIVE;  // RULE14
                end
                ffpp_pkg::ST_DRIVE: begin
                    if (oe_n) state <= ffpp_pkg::ST_WAIT_STB;  // RULE14
                end
                ffpp_pkg::ST_FLUSH: begin
                    if (flush_cmd == `CMD_ERASE_WR || flush_cmd == `CMD_ERASE_WR_LOCK) begin
                        state <= ffpp_pkg::ST_ERASE;  // RULE20 RULE21
                    end else begin
                        state <= ffpp_pkg::ST_PROG;
                    end
                end
                ffpp_pkg::ST_ERASE: begin
                    if (!i_flash_busy) state <= ffpp_pkg::ST_PROG;  // RULE20
                end
                ffpp_pkg::ST_PROG: begin
                    if (!fifo_out_valid && !i_flash_busy) begin
                        if (flush_cmd == `CMD_PAGE_WR_LOCK || flush_cmd == `CMD_ERASE_WR_LOCK) begin
                            state <= ffpp_pkg::ST_LOCK;  // RULE19 RULE21
                        end else begin
                            state <= ffpp_pkg::ST_EXEC;
                        end
                    end
                end
                ffpp_pkg::ST_LOCK: begin
                    state <= ffpp_pkg::ST_EXEC;
                end
                ffpp_pkg::ST_WAIT_STB: begin
                    if (stb_n) state <= ffpp_pkg::ST_IDLE;  // RULE11
                end
                default: state <= ffpp_pkg::ST_IDLE;
            endcase
        end
    end

    // latch mode and data on the strobe falling
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lat_mode <= 4'hF;
            lat_data <= `ZERO16;
        end else if (state == ffpp_pkg::ST_IDLE && !stb_n) begin
            lat_mode <= i_mode;  // RULE11
            lat_data <= i_data;
        end
    end

    // ----------------------------------------
    // register routing by mode
    // ----------------------------------------
    logic exec_done;
    assign exec_done = (state == ffpp_pkg::ST_EXEC) && !(lat_mode == `MODE_CMD && buf_dirty)
        && !(lat_mode == `MODE_DATA && is_write_cmd(command) && (page_change || !fifo_in_ready));

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            command <= `CMD_NONE;
        end else if (exec_done && lat_mode == `MODE_CMD) begin
            command <= lat_data;  // RULE2
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            addr_lo <= `ZERO16;
            addr_hi <= `ZERO16;
        end else if (state == ffpp_pkg::ST_DRIVE && oe_n && command == `CMD_READ) begin
            {addr_hi, addr_lo} <= addr + 32'h1;  // RULE16 RULE26
        end else if (exec_done) begin
            unique case (lat_mode)
                `MODE_ADDR_LO: addr_lo <= lat_data;  // RULE1
                `MODE_ADDR_HI: addr_hi <= lat_data;  // RULE1
                `MODE_DATA: begin
                    if (is_write_cmd(command) || command == `CMD_MEM_WR) begin
                        {addr_hi, addr_lo} <= addr + 32'h1;  // RULE17 RULE26
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // page buffer bookkeeping
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            buf_dirty <= 1'b0;
            page_base <= 32'h0;
            flush_cmd <= `CMD_NONE;
        end else if (state == ffpp_pkg::ST_EXEC && !exec_done && buf_dirty) begin
            flush_cmd <= command;  // RULE15
        end else if (fifo_push) begin
            buf_dirty <= 1'b1;  // RULE17
            if (!buf_dirty) page_base <= addr;
        end else if (state == ffpp_pkg::ST_PROG && !fifo_out_valid && !i_flash_busy) begin
            buf_dirty <= 1'b0;  // RULE18
        end
    end
    assign pend_cmd = flush_cmd;

    // nonvolatile bits
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lock_bits <= `ZERO16;
            gp_bits   <= `ZERO16;
            security  <= 1'b0;
        end else if (state == ffpp_pkg::ST_LOCK) begin
            lock_bits <= lock_bits | (16'h1 << page_base[PW+3:PW]);  // RULE19 RULE21
        end else if (exec_done && lat_mode == `MODE_DATA) begin
            unique case (command)
                `CMD_LOCK_SET: lock_bits <= lock_bits | lat_data;  // RULE5
                `CMD_LOCK_CLR: lock_bits <= lock_bits & ~lat_data;  // RULE5
                `CMD_GP_SET:   gp_bits   <= gp_bits | lat_data;  // RULE6
                `CMD_GP_CLR:   gp_bits   <= gp_bits & ~lat_data;  // RULE6
                `CMD_SEC_SET:  security  <= 1'b1;  // RULE8
                `CMD_ERASE_ALL: begin
                    if (lock_bits == `ZERO16) gp_bits <= `ZERO16;  // RULE4
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // flash side strobes and read data
    // ----------------------------------------
    logic [15:0] read_word;
    always_comb begin
        unique case (command)
            `CMD_LOCK_GET: read_word = lock_bits;
            `CMD_GP_GET:   read_word = gp_bits;
            `CMD_SEC_GET:  read_word = {15'h0, security};
            `CMD_VER_GET:  read_word = VERSION;
            default:   read_word = i_flash_rdata;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_data         <= `ZERO16;
            o_data_oe      <= 1'b0;
            o_data_valid_n <= 1'b1;
        end else begin
            if (state == ffpp_pkg::ST_WAIT_OE && !oe_n) o_data <= read_word;  // RULE14
            o_data_oe      <= (state == ffpp_pkg::ST_WAIT_OE && !oe_n)
                              || (state == ffpp_pkg::ST_DRIVE && !oe_n);
            o_data_valid_n <= !((state == ffpp_pkg::ST_WAIT_OE && !oe_n)
                              || (state == ffpp_pkg::ST_DRIVE && !oe_n));  // RULE24
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_flash_addr   <= 32'h0;
            o_flash_wdata  <= `ZERO16;
            o_flash_write  <= 1'b0;
            o_flash_read   <= 1'b0;
            o_page_erase   <= 1'b0;
            o_page_program <= 1'b0;
            o_full_erase   <= 1'b0;
            o_region_lock  <= 1'b0;
        end else begin
            o_flash_addr   <= fifo_pop ? fifo_out_addr : addr;  // RULE26
            o_flash_wdata  <= fifo_pop ? fifo_out_word : lat_data;
            o_flash_write  <= (fifo_pop && fifo_out_valid)
                              || (exec_done && lat_mode == `MODE_DATA && command == `CMD_MEM_WR);
            o_flash_read   <= state == ffpp_pkg::ST_WAIT_OE && command == `CMD_READ;  // RULE3
            o_page_erase   <= state == ffpp_pkg::ST_FLUSH
                              && (pend_cmd == `CMD_ERASE_WR || pend_cmd == `CMD_ERASE_WR_LOCK);  // RULE20
            o_page_program <= state == ffpp_pkg::ST_PROG;
            o_full_erase   <= exec_done && lat_mode == `MODE_DATA && command == `CMD_ERASE_ALL
                              && lock_bits == `ZERO16;  // RULE4
            o_region_lock  <= state == ffpp_pkg::ST_LOCK;  // RULE19
        end
    end

    assign o_ready     = (state == ffpp_pkg::ST_IDLE);  // RULE23
    assign o_lock_bits = lock_bits;
    assign o_gp_bits   = gp_bits;
    assign o_security  = security;
    assign o_command   = command;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_ready_drops: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE11
        (o_ready && !stb_n) |=> !o_ready) else $error("ready did not drop");
    chk_ready_needs_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE10
        ($rose(o_ready)) |-> $past(stb_n)) else $error("ready rose with strobe low");
    chk_valid_oe: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE24
        o_data_oe == !o_data_valid_n) else $error("valid and bus direction differ");
    chk_valid_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE14
        (state == ffpp_pkg::ST_DRIVE && oe_n) |=> o_data_valid_n) else $error("bus held");
    chk_cmd_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE2
        (exec_done && lat_mode == `MODE_CMD) |=> command == $past(lat_data))
        else $error("command not stored");
    chk_addr_lo: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE1
        (exec_done && lat_mode == `MODE_ADDR_LO) |=> addr_lo == $past(lat_data))
        else $error("address low not loaded");
    chk_flush_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE15
        (state == ffpp_pkg::ST_EXEC && lat_mode == `MODE_CMD && buf_dirty)
        |=> state == ffpp_pkg::ST_FLUSH) else $error("no flush before command");
    chk_lock_after: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE19
        o_region_lock |-> $past(state, 2) == ffpp_pkg::ST_PROG) else $error("lock early");
    chk_sync_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // RULE25
        stb_n == $past(i_cmd_strobe_n, 2)) else $error("strobe sync depth");
    cov_read: cover property (@(posedge i_clk) state == ffpp_pkg::ST_DRIVE);
    cov_flush: cover property (@(posedge i_clk) state == ffpp_pkg::ST_FLUSH);
    cov_lock: cover property (@(posedge i_clk) state == ffpp_pkg::ST_LOCK);
    cov_erase: cover property (@(posedge i_clk) state == ffpp_pkg::ST_ERASE);
endmodule : ffpp_port
`default_nettype wire
